// *** common/mrc_pkg.sv ***
package mrc_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned PCLK_NS          = 50;
  // Fixed re-arm interval of the timed variants, in nanoseconds.
  localparam int unsigned REARM_NS         = 2600;
  // A longest time rounds down to whole clock cycles.
  localparam int unsigned REARM_TIME_CYC   = REARM_NS / PCLK_NS;
  // Re-arm intervals counted in conversion pulses (samp_en).
  localparam int unsigned REARM_SINGLE_CYC = 304;
  localparam int unsigned REARM_DUAL_CYC   = 152;
  // Pre-trigger ceiling of the small-memory variant (32K samples).
  localparam int unsigned PRE_MAX_SMALL    = 32768;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [15:0] OFS_CTRL     = 16'h0000;
  localparam logic [15:0] OFS_PRE      = 16'h0004;
  localparam logic [15:0] OFS_POST     = 16'h0008;
  localparam logic [15:0] OFS_SEGS     = 16'h000C;
  localparam logic [15:0] OFS_STATUS   = 16'h0010;
  localparam logic [15:0] OFS_IRQ_STAT = 16'h0014;
  localparam logic [15:0] OFS_IRQ_MASK = 16'h0018;
  localparam logic [15:0] OFS_LAST_PTR = 16'h001C;
  localparam int unsigned MEM_WIN_BIT  = 15;

  // Control fields.
  localparam int unsigned CTRL_START     = 0;
  localparam int unsigned CTRL_ABORT     = 1;
  localparam int unsigned CTRL_SINGLE    = 2;
  localparam int unsigned CTRL_ONE_MEM   = 3;
  localparam int unsigned CTRL_FULL_RATE = 4;
  localparam int unsigned CTRL_MULTI     = 5;

  // Status fields.
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_ARMED = 1;

  // Interrupt status and mask fields.
  localparam int unsigned EV_SEG  = 0;
  localparam int unsigned EV_DONE = 1;
  localparam int unsigned EV_FULL = 2;

  // Reset values.
  localparam logic [31:0] PRE_RST  = 32'h0000_0000;
  localparam logic [31:0] POST_RST = 32'h0000_0100;
  localparam logic [31:0] SEGS_RST = 32'h0000_0001;
  localparam logic [2:0]  MASK_RST = 3'h0;

  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_POST, ST_REARM} mrc_state_t;

endpackage

// *** hdl/mrc_capture.sv ***
`timescale 1ns/10ps
// What this block does
// - Each trigger heard while armed captures a new segment, stacked consecutively in on-board memory.
// - Every segment may hold samples taken before its trigger.
// - Software sets pre-trigger length; accepted from zero up to the variant ceiling.
// - After a segment the trigger re-arms itself within a fixed interval.
// - Dual-only variants offer no single-channel external-clock acquisition.
// - Other variants let software pick single or dual channel on external clock.
// - One selectable mode gives one channel all memory; dual timing unchanged.
// - Some variants convert on every second external edge in dual mode.
// - One variant converts on every eighth external edge in dual mode.
// - Sample on rising edges; one variant uses both edges in single mode.
// - Optional full-rate external clock samples on every rising edge in dual mode.
// - Start sets busy and blocks memory reads until acquisition stops.
// - Software sets post-trigger count; packed modes round it up to whole two-sample words.
module mrc_capture
  import mrc_pkg::*;
#(
  parameter int unsigned SW            = 14,
  parameter int unsigned MEM_AW        = 12,
  parameter bit          DUAL_ONLY     = 1'b0,
  parameter bit          BOTH_EDGE_SGL = 1'b0,
  parameter int unsigned DUAL_DIV      = 2,
  parameter bit          FULL_RATE_OPT = 1'b0,
  parameter int unsigned PRE_MAX       = PRE_MAX_SMALL,
  parameter bit          REARM_TIMED   = 1'b0
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic [15:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Acquisition pins
  input  wire logic              external_sample_clock,
  input  wire logic              trig_pin,
  input  wire logic [SW-1:0]     chan_a,
  input  wire logic [SW-1:0]     chan_b,
  // Status outputs
  output logic                   irq,
  output logic                   busy
);

  localparam int unsigned DEPTH = 1 << MEM_AW;

  function automatic logic [31:0] words_of(input logic [31:0] n, input logic pk);
    return pk ? ((n + 32'h1) >> 1) : n;
  endfunction

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic          ck_s1, ck_s2, ck_s3, tg_s1, tg_s2, tg_s3;
  logic [SW-1:0] a_s1, a_s2, b_s1, b_s2;

  // The clock pin is sampled like data; the 400 ns link period leaves ample margin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ck_s1, ck_s2, ck_s3} <= 3'h0;
      {tg_s1, tg_s2, tg_s3} <= 3'h0;
      {a_s1, a_s2, b_s1, b_s2} <= '0;
    end else begin
      {ck_s3, ck_s2, ck_s1} <= {ck_s2, ck_s1, external_sample_clock};
      {tg_s3, tg_s2, tg_s1} <= {tg_s2, tg_s1, trig_pin};
      {a_s2, a_s1} <= {a_s1, chan_a};
      {b_s2, b_s1} <= {b_s1, chan_b};
    end
  end

  // ---------------------------------------------------------------------------
  // Mode decode and sample enable
  // ---------------------------------------------------------------------------
  logic [5:0]  ctrl;
  logic        single_eff, pack, edge_hit, samp_en;
  logic [31:0] div_eff, dcnt;

  assign single_eff = ctrl[CTRL_SINGLE] && !DUAL_ONLY;
  assign pack       = single_eff || ctrl[CTRL_ONE_MEM];
  assign div_eff    = (single_eff || (FULL_RATE_OPT && ctrl[CTRL_FULL_RATE])) ? 32'h1
                    : 32'(DUAL_DIV);
  assign edge_hit   = (ck_s2 && !ck_s3)
                    || (single_eff && BOTH_EDGE_SGL && !ck_s2 && ck_s3);

  // Divide the qualified external edges down to one conversion pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt    <= 32'h0;
      samp_en <= 1'b0;
    end else begin
      samp_en <= 1'b0;
      // A mode write restarts the divider, so a stale count never skews the new rate.
      if (psel && penable && pready && pwrite && paddr == OFS_CTRL && !busy) begin
        dcnt <= 32'h0;
      end else if (edge_hit) begin
        if (dcnt + 32'h1 >= div_eff) begin
          dcnt    <= 32'h0;
          samp_en <= 1'b1;
        end else begin
          dcnt <= dcnt + 32'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // APB decode and configuration registers
  // ---------------------------------------------------------------------------
  logic [31:0] pre_reg, post_reg, segs_reg, last_ptr;
  logic [2:0]  irq_stat, irq_mask;
  logic        apb_wr, rd_phase, start_wr, abort_wr;
  mrc_state_t  state;

  assign apb_wr   = psel && penable && pready && pwrite;
  assign rd_phase = psel && penable && !pready;
  assign start_wr = apb_wr && paddr == OFS_CTRL && pwdata[CTRL_START];
  assign abort_wr = apb_wr && paddr == OFS_CTRL && pwdata[CTRL_ABORT];

  // Settings other than the interrupt mask freeze while busy so a running capture never changes geometry.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= 6'h0;
      pre_reg  <= PRE_RST;
      post_reg <= POST_RST;
      segs_reg <= SEGS_RST;
      irq_mask <= MASK_RST;
    end else if (apb_wr) begin
      if (paddr == OFS_IRQ_MASK) irq_mask <= pwdata[2:0];
      if (!busy) begin
        unique case (paddr)
          OFS_CTRL: ctrl <= {pwdata[5:2], 2'b00};
          OFS_PRE:  pre_reg <= (pwdata > PRE_MAX) ? PRE_MAX : pwdata;
          OFS_POST: post_reg <= (pwdata == 32'h0) ? 32'h1 : pwdata;
          OFS_SEGS: segs_reg <= (pwdata == 32'h0) ? 32'h1 : pwdata;
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Acquisition sequencer
  // ---------------------------------------------------------------------------
  logic [31:0] pre_w, post_w, seg_words, base, woff, pre_cnt, post_cnt, seg_idx;
  logic [31:0] rearm_cnt, post_next, woff_next, next_base;
  logic [SW-1:0]   lo;
  logic [2*SW-1:0] word;
  logic        half, trig_pend, armed, wr_evt, take_trig, end_seg, mem_out, last_seg;
  logic [2*SW-1:0] mem [0:DEPTH-1];

  assign pre_w     = words_of(pre_reg, pack);
  assign post_w    = words_of(post_reg, pack);
  assign seg_words = pre_w + post_w;
  assign armed     = state == ST_PRE && pre_cnt >= pre_w;
  assign wr_evt    = samp_en && (state == ST_PRE || state == ST_POST) && (!pack || half);
  assign word      = pack ? {a_s2, lo} : {b_s2, a_s2};
  assign take_trig = wr_evt && state == ST_PRE && trig_pend;
  assign post_next = (state == ST_POST) ? post_cnt + 32'h1 : 32'h1;
  assign end_seg   = wr_evt && (state == ST_POST || take_trig) && post_next >= post_w;
  assign woff_next = (woff + 32'h1 >= seg_words) ? 32'h0 : woff + 32'h1;
  assign next_base = base + seg_words;
  assign mem_out   = next_base + seg_words > DEPTH;
  assign last_seg  = !ctrl[CTRL_MULTI] || seg_idx + 32'h1 >= segs_reg || mem_out;

  // Triggers are only heard while armed; earlier ones are dropped on purpose.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_pend <= 1'b0;
    end else if (take_trig || state != ST_PRE) begin
      trig_pend <= 1'b0;
    end else if (armed && tg_s2 && !tg_s3) begin
      trig_pend <= 1'b1;
    end
  end

  // Sample words are written without any host involvement between segments.
  always_ff @(posedge pclk) begin
    if (wr_evt) mem[MEM_AW'(base + woff)] <= word;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      busy  <= 1'b0;
      {base, woff, pre_cnt, post_cnt, seg_idx, rearm_cnt, last_ptr} <= '0;
      half  <= 1'b0;
      lo    <= '0;
    end else begin
      if (samp_en && pack && (state == ST_PRE || state == ST_POST)) begin
        half <= !half;
        if (!half) lo <= a_s2;
      end
      unique case (state)
        ST_IDLE: if (start_wr) begin
          state   <= ST_PRE;
          busy    <= 1'b1;
          {base, woff, pre_cnt, seg_idx} <= '0;
          half    <= 1'b0;
        end
        ST_PRE, ST_POST: begin
          if (abort_wr) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
          end else if (wr_evt) begin
            woff <= woff_next;
            if (state == ST_PRE && pre_cnt < pre_w) pre_cnt <= pre_cnt + 32'h1;
            if (state == ST_POST || take_trig) post_cnt <= post_next;
            if (end_seg) begin
              last_ptr <= woff_next;
              seg_idx  <= seg_idx + 32'h1;
              base     <= next_base;
              half     <= 1'b0;
              if (last_seg) begin
                state <= ST_IDLE;
                busy  <= 1'b0;
              end else begin
                state     <= ST_REARM;
                rearm_cnt <= REARM_TIMED ? 32'(REARM_TIME_CYC)
                           : single_eff ? 32'(REARM_SINGLE_CYC)
                           : 32'(REARM_DUAL_CYC);
              end
            end else if (take_trig) begin
              state <= ST_POST;
            end
          end
        end
        ST_REARM: begin
          if (abort_wr) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
          end else if (rearm_cnt == 32'h0) begin
            state   <= ST_PRE;
            {woff, pre_cnt} <= '0;
            half    <= 1'b0;
          end else if (REARM_TIMED || samp_en) begin
            rearm_cnt <= rearm_cnt - 32'h1;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------
  logic [2:0] ev, clr;

  assign ev  = {end_seg && !abort_wr && mem_out, end_seg && !abort_wr && last_seg,
                end_seg && !abort_wr};
  assign clr = (apb_wr && paddr == OFS_IRQ_STAT) ? pwdata[2:0] : 3'h0;

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 3'h0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~clr) | ev;
      irq      <= |(irq_stat & irq_mask);
    end
  end

  // ---------------------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------------------
  // Read data is fetched in the first access cycle and ready follows one cycle later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_phase;
      pslverr <= 1'b0;
      if (rd_phase) begin
        prdata <= 32'h0;
        if (paddr[MEM_WIN_BIT]) begin
          if (busy || pwrite) pslverr <= 1'b1;
          else prdata <= 32'(mem[paddr[MEM_AW+1:2]]);
        end else if (!pwrite) begin
          unique case (paddr)
            OFS_CTRL:     prdata <= {26'h0, ctrl};
            OFS_PRE:      prdata <= pre_reg;
            OFS_POST:     prdata <= post_reg;
            OFS_SEGS:     prdata <= segs_reg;
            OFS_STATUS:   prdata <= {30'h0, armed, busy};
            OFS_IRQ_STAT: prdata <= {29'h0, irq_stat};
            OFS_IRQ_MASK: prdata <= {29'h0, irq_mask};
            OFS_LAST_PTR: prdata <= last_ptr;
            default:      pslverr <= 1'b1;
          endcase
        end else if (paddr > OFS_LAST_PTR || paddr[1:0] != 2'b00) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_busy_start;
    @(posedge pclk) disable iff (!presetn) (state == ST_IDLE && start_wr) |=> busy;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("start did not set busy");

  property p_mem_locked;
    @(posedge pclk) disable iff (!presetn)
      (rd_phase && paddr[MEM_WIN_BIT] && busy) |=> (pready && pslverr);
  endproperty
  a_mem_locked: assert property (p_mem_locked) else $error("memory read while busy");

  property p_post_len;
    @(posedge pclk) disable iff (!presetn) state == ST_POST |-> post_cnt < post_w;
  endproperty
  a_post_len: assert property (p_post_len) else $error("post count overrun");

  property p_rearm;
    @(posedge pclk) disable iff (!presetn)
      (state == ST_REARM && rearm_cnt == 32'h0 && !abort_wr) |=> state == ST_PRE;
  endproperty
  a_rearm: assert property (p_rearm) else $error("no automatic re-arm");

  property p_seg_base;
    @(posedge pclk) disable iff (!presetn)
      (state != ST_IDLE && !abort_wr && end_seg)
        |=> base == $past(base) + $past(seg_words);
  endproperty
  a_seg_base: assert property (p_seg_base) else $error("segment not stacked");

  property p_trig_pre;
    @(posedge pclk) disable iff (!presetn) take_trig |-> pre_cnt >= pre_w;
  endproperty
  a_trig_pre: assert property (p_trig_pre) else $error("trigger before pre-fill");

  property p_rate;
    @(posedge pclk) disable iff (!presetn)
      samp_en |-> ($past(edge_hit) && $past(dcnt) + 32'h1 == $past(div_eff));
  endproperty
  a_rate: assert property (p_rate) else $error("wrong conversion rate");

  property p_pre_max;
    @(posedge pclk) disable iff (!presetn) pre_reg <= PRE_MAX;
  endproperty
  a_pre_max: assert property (p_pre_max) else $error("pre-trigger above ceiling");

  property p_irq;
    @(posedge pclk) disable iff (!presetn) ##1 irq == $past(|(irq_stat & irq_mask));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output mismatch");

endmodule

// *** verif/mrc_src_model.sv ***
`timescale 1ns/10ps
// -----------------------------------------------------------------------------
// External sample clock source and analog inputs
// -----------------------------------------------------------------------------
module mrc_src_model #(
  parameter int unsigned SW   = 14,
  parameter int unsigned HALF = 200
) (
  // Control from the bench
  input  wire logic          run,
  input  wire logic          fire,
  // Far-side pins
  output logic               ext_clk,
  output logic               trig,
  output logic [SW-1:0]      a,
  output logic [SW-1:0]      b
);
  logic [SW-1:0] cnt;

  // Start quiet with the clock low.
  initial begin
    ext_clk = 1'b0;
    trig = 1'b0;
    cnt = '0;
    a = '0;
    b = '1;
  end

  // The clock stands still between runs, as a gated source would.
  always begin
    #HALF;
    if (run) begin
      ext_clk = ~ext_clk;
    end
  end

  // Data moves on the falling edge so it is settled at every rising edge.
  always @(negedge ext_clk) begin
    cnt = cnt + 1'b1;
    a = cnt;
    b = ~cnt;
  end

  // A long pulse, so the slow synchroniser cannot miss it.
  always @(posedge fire) begin
    trig = 1'b1;
    #300;
    trig = 1'b0;
  end
endmodule

// *** verif/multi_record_ext_clock_capture_test.sv ***
`timescale 1ns/10ps
module multi_record_ext_clock_capture_test import mrc_pkg::*;;
  localparam int unsigned SW     = 14;
  localparam int unsigned PRE_N  = 4;
  localparam int unsigned POST_N = 6;
  typedef struct {logic [15:0] addr; logic [31:0] data; logic err;} mrc_row_t;

  // -----------------------------------------------------------------------------
  // Signals and instances
  // -----------------------------------------------------------------------------
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [15:0]   paddr;
  logic [31:0]   pwdata, prdata, q;
  logic          ext_clk, trig, irq, busy, run, fire, e;
  logic [SW-1:0] chan_a, chan_b;
  int            fails, checked;
  mrc_row_t      rows [9];

  mrc_capture #(.SW(SW), .MEM_AW(6)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_sample_clock(ext_clk), .trig_pin(trig),
    .chan_a(chan_a), .chan_b(chan_b), .irq(irq), .busy(busy));

  mrc_src_model #(.SW(SW)) src_u (.run(run), .fire(fire), .ext_clk(ext_clk), .trig(trig),
    .a(chan_a), .b(chan_b));

  // Free-running system clock.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // -----------------------------------------------------------------------------
  // Checks, bus cycles and verdict
  // -----------------------------------------------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic        re;
    apb(1'b1, a, d, rq, re);
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] rq);
    logic re;
    apb(1'b0, a, 32'h0, rq, re);
  endtask

  // Polls a status bit under a bounded count.
  task automatic wait_stat(input int bitn, input logic val);
    logic [31:0] rq;
    int          n;
    n = 0;
    do begin
      rd(OFS_STATUS, rq);
      n++;
    end while (rq[bitn] !== val && n < 3000);
    if (n == 3000) begin
      fails++;
      $display("MISMATCH t=%0t status bit stuck", $time);
    end
  endtask

  // One acquisition: one trigger per segment, each only once the logic is armed.
  task automatic capture(input logic [31:0] ctrl, input int segs);
    wr(OFS_PRE, PRE_N);
    wr(OFS_POST, POST_N);
    wr(OFS_SEGS, 32'(segs));
    run <= 1'b1;
    wr(OFS_CTRL, ctrl | 32'h1);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk_bit(busy, 1'b1);
    apb(1'b0, 16'h8000, 32'h0, q, e);
    chk_bit(e, 1'b1);
    wr(OFS_PRE, 32'h9);
    for (int s = 0; s < segs; s++) begin
      wait_stat(STAT_ARMED, 1'b1);
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
      wait_stat(STAT_ARMED, 1'b0);
    end
    wait_stat(STAT_BUSY, 1'b0);
    run <= 1'b0;
    rd(OFS_PRE, q);
    chk_word(q, PRE_N);
  endtask

  // Walks a segment's ring from its oldest word and checks sample order.
  task automatic check_ring(input int base, input int nw, input bit pk, input int step);
    logic [31:0]   rq, ptr;
    logic [SW-1:0] lo, hi, last, d;
    int            idx;
    rd(OFS_LAST_PTR, ptr);
    for (int k = 0; k < nw; k++) begin
      idx = base + (int'(ptr) + k) % nw;
      rd(16'h8000 + 16'(4 * idx), rq);
      lo = rq[SW-1:0];
      hi = rq[2*SW-1:SW];
      if (pk) begin
        d = hi - lo;
        chk_word(32'(d), 32'(step));
        d = lo - last;
        if (k > 0) chk_word(32'(d), 32'(step));
        last = hi;
      end else begin
        d = ~lo;
        chk_word(32'(hi), 32'(d));
        d = lo - last;
        if (k > 0) chk_word(32'(d), 32'(step));
        last = lo;
      end
    end
  endtask

  // -----------------------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    run = 1'b0;
    fire = 1'b0;
    fails = 0;
    checked = 0;
    rows = '{'{OFS_CTRL, 32'h0, 1'b0}, '{OFS_PRE, PRE_RST, 1'b0}, '{OFS_POST, POST_RST, 1'b0},
             '{OFS_SEGS, SEGS_RST, 1'b0}, '{OFS_STATUS, 32'h0, 1'b0},
             '{OFS_IRQ_STAT, 32'h0, 1'b0}, '{OFS_IRQ_MASK, 32'h0, 1'b0},
             '{16'h0020, 32'h0, 1'b1}, '{16'h0006, 32'h0, 1'b1}};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].addr, 32'h0, q, e);
      chk_word(q, rows[i].data);
      chk_bit(e, rows[i].err);
    end
    // Two stacked dual-channel segments; only the done event is unmasked.
    wr(OFS_IRQ_MASK, 32'h1 << EV_DONE);
    capture(32'h1 << CTRL_MULTI, 2);
    check_ring(PRE_N + POST_N, PRE_N + POST_N, 1'b0, 2);
    rd(OFS_IRQ_STAT, q);
    chk_word(q, 32'h3);
    @(negedge pclk);
    chk_bit(irq, 1'b1);
    wr(OFS_IRQ_STAT, 32'h1 << EV_DONE);
    repeat (3) @(negedge pclk);
    chk_bit(irq, 1'b0);
    rd(OFS_IRQ_STAT, q);
    chk_word(q, 32'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    // Single channel packs two samples per word, one sample per rising edge.
    capture(32'h1 << CTRL_SINGLE, 1);
    check_ring(0, (PRE_N + 1) / 2 + (POST_N + 1) / 2, 1'b1, 1);
    // One-channel memory packs channel A but keeps the dual rate of one sample per two edges.
    capture(32'h1 << CTRL_ONE_MEM, 1);
    check_ring(0, (PRE_N + 1) / 2 + (POST_N + 1) / 2, 1'b1, 2);
    complete_run();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (90000) @(posedge pclk);
    fails++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    complete_run();
  end
endmodule
